// [pkg/conv_pkg.sv]
package conv_pkg;
   localparam int RESULT_BITS     = 12;
   localparam int HI_NIBBLE_LSB   = 8;
   localparam int MID_NIBBLE_LSB  = 4;
   localparam int NIBBLE_BITS     = 4;
   localparam int CLK_PERIOD_NS   = 10;
   localparam int CONV_TIME_NS    = 2700;
   localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int STEP_CYCLES     = CONV_CYCLES / RESULT_BITS;
   localparam int MIN_LOW_NS      = 40;
   localparam int MIN_LOW_CYCLES  = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [11:0] MSB_TRIAL    = 12'h800;

   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_STEP   = 2'b01,
      SEQ_LATCH  = 2'b11
   } seq_state_e;
endpackage

// [pkg/sar_if.sv]
`timescale 1ns/1ns
interface sar_if;
   logic        start;
   logic        done;
   logic        comp_in;
   logic [11:0] trial;
   logic [11:0] result;
   modport ctrl (output start, input done, input result, output comp_in, input trial);
   modport seq  (input start, output done, output result, input comp_in, output trial);
endinterface

// [logic/sar_sequencer.sv]
`timescale 1ns/1ns
module sar_sequencer
   import conv_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst_b,
   sar_if.seq        bus
);
   seq_state_e  state_reg, state_next;
   logic [11:0] trial_reg, trial_next;
   logic [11:0] bit_reg, bit_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [11:0] res_reg, res_next;
   logic        done_reg, done_next;

   always_comb begin
      state_next = state_reg;
      trial_next = trial_reg;
      bit_next   = bit_reg;
      cnt_next   = cnt_reg;
      res_next   = res_reg;
      done_next  = 1'b0;
      unique case (state_reg)
         SEQ_IDLE: begin
            if (bus.start) begin
               trial_next = MSB_TRIAL;
               bit_next   = MSB_TRIAL;
               cnt_next   = 16'h0000;
               state_next = SEQ_STEP;
            end
         end
         SEQ_STEP: begin
            // One bit decided per fixed step
            if (cnt_reg == 16'(STEP_CYC - 1)) begin
               cnt_next = 16'h0000;
               if (!bus.comp_in)
                  trial_next = trial_reg & ~bit_reg;
               if (bit_reg[0])
                  state_next = SEQ_LATCH;
               else
                  trial_next = (bus.comp_in ? trial_reg : trial_reg & ~bit_reg) | (bit_reg >> 1);
               bit_next = bit_reg >> 1;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end
         SEQ_LATCH: begin
            res_next   = trial_reg;
            done_next  = 1'b1;
            state_next = SEQ_IDLE;
         end
         default: state_next = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= SEQ_IDLE;
         trial_reg <= RESULT_RESET;
         bit_reg   <= RESULT_RESET;
         cnt_reg   <= 16'h0000;
         res_reg   <= RESULT_RESET;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         trial_reg <= trial_next;
         bit_reg   <= bit_next;
         cnt_reg   <= cnt_next;
         res_reg   <= res_next;
         done_reg  <= done_next;
      end
   end

   assign bus.trial  = trial_reg;
   assign bus.result = res_reg;
   assign bus.done   = done_reg;
endmodule // sar_sequencer

// [logic/sar_adc_host_interface.sv]
`timescale 1ns/1ns
// Function
// - With byte select low all twelve result bits appear on the data lines together.
// - Lines for bits 7..4 carry those bits with byte select low and are driven low when high.
// - Lines for bits 3..0 carry bits 3..0 with byte select low and bits 11..8 when high.
// - With byte select low line 11 is the result MSB and line 0 the LSB, bits 11..8 on their own lines.
// - A falling read/convert edge starts a conversion only with select low, byte select low, busy high.
// - With chip select high every data line floats.
// - Busy is low for the whole conversion and high otherwise.
// - The result is valid at the rising edge of busy.
// - During conversion start pulses are ignored and data lines float.
// - Data drivers are on only while read/convert and busy are high, with chip select low.
// - Busy rises only after the result sits in the output latches.
module sar_adc_host_interface
   import conv_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   chip_select_b,
   input  wire logic                   read_convert,
   input  wire logic                   byte_select_high,
   input  wire logic                   comparator_in,
   output logic      [RESULT_BITS-1:0] data_out,
   output logic      [RESULT_BITS-1:0] data_oe,
   output logic                        busy_b,
   output logic      [RESULT_BITS-1:0] dac_trial,
   output logic                        sample_hold
);
   sar_if sif ();

   // Pin synchronisers
   logic [2:0] cs_sync1_reg, cs_sync2_reg;
   logic [2:0] sync_next;
   logic       rc_prev_reg;
   logic       comp_s1_reg, comp_s2_reg;

   always_comb begin
      sync_next = {chip_select_b, read_convert, byte_select_high};
   end

   // Read/convert resets low so a pin held low at release gives no false start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_sync1_reg <= 3'h5;
         cs_sync2_reg <= 3'h5;
         rc_prev_reg  <= 1'b0;
         comp_s1_reg  <= 1'b0;
         comp_s2_reg  <= 1'b0;
      end else begin
         cs_sync1_reg <= sync_next;
         cs_sync2_reg <= cs_sync1_reg;
         rc_prev_reg  <= cs_sync2_reg[1];
         comp_s1_reg  <= comparator_in;
         comp_s2_reg  <= comp_s1_reg;
      end
   end

   logic cs_b_s, rc_s, hbe_s;
   assign cs_b_s = cs_sync2_reg[2];
   assign rc_s   = cs_sync2_reg[1];
   assign hbe_s  = cs_sync2_reg[0];

   // Output and control state
   logic                   busy_b_reg, busy_b_next;
   logic                   start_reg, start_next;
   logic [RESULT_BITS-1:0] dout_reg, dout_next;
   logic [RESULT_BITS-1:0] oe_reg, oe_next;
   logic                   hold_reg, hold_next;
   logic                   fall;

   assign fall = rc_prev_reg & ~rc_s;

   always_comb begin
      busy_b_next = busy_b_reg;
      start_next  = 1'b0;
      hold_next   = hold_reg;
      // Start qualified by all three pin conditions
      if (fall && !cs_b_s && !hbe_s && busy_b_reg && !start_reg) begin
         start_next  = 1'b1;
         busy_b_next = 1'b0;
         hold_next   = 1'b1;
      end
      // Busy released one cycle after result latched
      if (sif.done) begin
         busy_b_next = 1'b1;
         hold_next   = 1'b0;
      end
      dout_next = sif.result;
      if (hbe_s) begin
         dout_next[HI_NIBBLE_LSB-1 -: NIBBLE_BITS] = '0;
         dout_next[MID_NIBBLE_LSB-1 -: NIBBLE_BITS] =
            sif.result[RESULT_BITS-1 -: NIBBLE_BITS];
      end
      // Drivers on only when selected, reading and idle
      oe_next = '0;
      if (!cs_b_s && rc_s && busy_b_next) begin
         oe_next = '1;
         if (hbe_s)
            oe_next[RESULT_BITS-1 -: NIBBLE_BITS] = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_b_reg <= 1'b1;
         start_reg  <= 1'b0;
         dout_reg   <= RESULT_RESET;
         oe_reg     <= '0;
         hold_reg   <= 1'b0;
      end else begin
         busy_b_reg <= busy_b_next;
         start_reg  <= start_next;
         dout_reg   <= dout_next;
         oe_reg     <= oe_next;
         hold_reg   <= hold_next;
      end
   end

   assign sif.start   = start_reg;
   assign sif.comp_in = comp_s2_reg;

   sar_sequencer #(
      .STEP_CYC (STEP_CYC)
   ) u_seq (
      .clk   (clk),
      .rst_b (rst_b),
      .bus   (sif.seq)
   );

   logic [RESULT_BITS-1:0] trial_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         trial_reg <= RESULT_RESET;
      else
         trial_reg <= sif.trial;
   end

   assign data_out    = dout_reg;
   assign data_oe     = oe_reg;
   assign busy_b      = busy_b_reg;
   assign dac_trial   = trial_reg;
   assign sample_hold = hold_reg;
endmodule // sar_adc_host_interface

// [tb/sar_comparator_model.sv]
`timescale 1ns/1ns
module sar_comparator_model (
   input  wire logic [11:0] dac_trial,
   input  wire logic [11:0] level,
   output logic             comparator_in
);
   // Keep the trial bit while the trial does not exceed the held input
   assign comparator_in = (dac_trial <= level);
endmodule // sar_comparator_model

// [tb/sar_adc_host_interface_chk.sv]
`timescale 1ns/1ns
module sar_adc_host_interface_chk
   import conv_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
) (
   input wire logic                   clk,
   input wire logic                   rst_b,
   input wire logic                   chip_select_b,
   input wire logic                   read_convert,
   input wire logic                   byte_select_high,
   input wire logic [RESULT_BITS-1:0] data_out,
   input wire logic [RESULT_BITS-1:0] data_oe,
   input wire logic                   busy_b,
   input wire logic                   sample_hold
);
   localparam int LOW_MIN = RESULT_BITS * STEP_CYC;
   localparam int LOW_MAX = RESULT_BITS * STEP_CYC + 5;
   int low_cnt_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Cycles spent with busy low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) low_cnt_reg <= 0;
      else low_cnt_reg <= busy_b ? 0 : low_cnt_reg + 1;
   end
   a_start_answer: assert property (($fell(read_convert) && busy_b && !chip_select_b
      && !byte_select_high && !$past(chip_select_b, 3) && !$past(byte_select_high, 3))
      |-> ##[3:4] $fell(busy_b)) else $error("start not answered by busy");
   a_byte_refused: assert property ($fell(read_convert) && byte_select_high
      && $past(byte_select_high, 3) && busy_b |-> busy_b[*6]) else $error("start in byte mode");
   a_cs_refused: assert property ($fell(read_convert) && chip_select_b
      && $past(chip_select_b, 3) && busy_b |-> busy_b[*6]) else $error("start while deselected");
   a_busy_float: assert property (!busy_b |-> data_oe == 12'h000)
      else $error("lines driven during conversion");
   a_cs_float: assert property (chip_select_b && $past(chip_select_b, 3) |-> data_oe == 12'h000)
      else $error("lines driven while deselected");
   a_rc_float: assert property (!read_convert && !$past(read_convert, 3)
      |-> data_oe == 12'h000) else $error("lines driven with read/convert low");
   a_byte_lines: assert property (byte_select_high && $past(byte_select_high, 3)
      |-> data_out[7:4] == 4'h0 && data_oe[11:8] == 4'h0) else $error("byte mode lines");
   a_busy_length: assert property ($rose(busy_b) |-> low_cnt_reg >= LOW_MIN
      && low_cnt_reg <= LOW_MAX) else $error("busy low length wrong");
   a_hold_busy: assert property (sample_hold == !busy_b)
      else $error("hold state differs from busy");
endmodule // sar_adc_host_interface_chk
bind sar_adc_host_interface sar_adc_host_interface_chk #(.STEP_CYC(STEP_CYC)) chk_i (.clk,
   .rst_b, .chip_select_b, .read_convert, .byte_select_high, .data_out, .data_oe, .busy_b,
   .sample_hold);

// [tb/sar_adc_host_interface_tb_top.sv]
`timescale 1ns/1ns
module sar_adc_host_interface_tb_top;
   import conv_pkg::*;
   logic        clk = 0;
   logic        rst_b = 0;
   logic        chip_select_b = 1;
   logic        read_convert = 1;
   logic        byte_select_high = 0;
   logic        comparator_in;
   logic        busy_b;
   logic [11:0] data_out, data_oe, dac_trial, level = 0, last_oe = 0;
   logic [23:0] exp_q[$];
   logic [23:0] n;
   int          err_count = 0, checks_done = 0, seed = 53264, k;
   always #5 clk = ~clk;
   // Comparator loop takes three cycles, so a step needs at least four
   sar_adc_host_interface #(.STEP_CYC(4)) sar_adc_host_interface_i (.clk, .rst_b, .chip_select_b,
      .read_convert, .byte_select_high, .comparator_in, .data_out, .data_oe, .busy_b,
      .dac_trial, .sample_hold());
   sar_comparator_model sar_comparator_model_i (.dac_trial, .level, .comparator_in);
   task automatic cmp12(logic [11:0] got, logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(logic got, logic exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t busy %b expected %b", $time, got, exp);
      end
   endtask
   task automatic tick(int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic pulse();
      read_convert = 0;
      tick(5);
      read_convert = 1;
   endtask
   task conclude();
      if (exp_q.size() != 0) begin
         err_count++;
         $display("FAIL %0t expected results never appeared", $time);
      end
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Compare settled lines once drivers switch on
   initial forever begin
      @(negedge clk);
      if (data_oe !== last_oe && data_oe !== 12'h000) begin
         tick(4);
         n = exp_q.pop_front();
         cmp12(data_oe, n[23:12]);
         cmp12(data_out & data_oe, n[11:0]);
      end
      last_oe = data_oe;
   end
   initial begin
      #100000;
      err_count++;
      $display("FAIL %0t timeout", $time);
      conclude();
   end
   initial begin
      tick(5);
      rst_b = 1;
      tick(3);
      exp_q.push_back({12'hfff, RESULT_RESET});
      chip_select_b = 0;
      tick(8);
      for (int i = 0; i < 6; i++) begin
         level = i == 0 ? 12'h000 : i == 1 ? 12'hfff : 12'($random(seed));
         exp_q.push_back({12'hfff, level});
         pulse();
         if (i[0]) begin
            tick(8);
            pulse();
         end
         for (k = 0; k < 100 && busy_b !== 1'b1; k++) tick(1);
         tick(8);
         exp_q.push_back({12'h0ff, 8'h00, level[11:8]});
         byte_select_high = 1;
         tick(8);
         exp_q.push_back({12'h0ff, 8'h00, level[11:8]});
         pulse();
         tick(8);
         cmp1(busy_b, 1'b1);
         chip_select_b = 1;
         tick(6);
         cmp12(data_oe, 12'h000);
         pulse();
         tick(6);
         cmp1(busy_b, 1'b1);
         exp_q.push_back({12'hfff, level});
         byte_select_high = 0;
         chip_select_b = 0;
         tick(8);
         $display("test %0d done", i);
      end
      conclude();
   end
endmodule // sar_adc_host_interface_tb_top
